//--- include/qdac_defines.svh
// constants of the quad dac two-wire control block
// assumes a single 50 MHz clk and an asynchronous active-low reset
//
// Function
// - reset clears input and output registers
// - slave only, serial clock never driven
// - address is 000110 plus select pin
// - start opens address byte with direction
// - acknowledge own address, else stay idle
// - nine clocks per byte, data while low
// - write: address, pointer, then data bytes
// - read: pointer write, restart, read address
// - bare read address reuses stored pointer
// - pointer low nibble selects channels
// - two bytes form word, high byte first
// - mode bits, clear bit13, load bit12
// - code left-justified from bit 11
// - clear low zeroes all inputs and output codes
// - load low updates outputs of fresh inputs
// - load high updates addressed inputs and power modes only
// - output code is straight unsigned binary
// - mode bits 15:14 select power-down kind
// - no single channel reads default word
// - load copies only freshly written inputs
// - acked read repeats same two bytes
`ifndef QDAC_DEFINES_SVH
`define QDAC_DEFINES_SVH

// ==========================================================
// addressing and bit positions
`define QDAC_ADDR_HI     6'h06
`define QDAC_BIT_PM_HI   15
`define QDAC_BIT_PM_LO   14
`define QDAC_BIT_CLEAR_N 13
`define QDAC_BIT_LOAD_N  12
`define QDAC_CODE_MSB    11

// ==========================================================
// reset values and bit counts
`define QDAC_RB_DEFAULT  16'h2000
`define QDAC_WORD_RST    16'h0000
`define QDAC_CODE_RST    12'h000
`define QDAC_PTR_RST     4'h0
`define QDAC_LAST_BIT    4'h7
`define QDAC_ACK_BIT     4'h8

`endif

//--- include/qdac_pkg.sv
// types of the quad dac two-wire control block
// uses no constant of qdac_defines.svh, its enum codes are literals
`default_nettype none
package qdac_pkg;

   // ==========================================================
   // protocol states
   typedef enum logic [4:0] {
      QDAC_IDLE = 5'h01,
      QDAC_ADDR = 5'h02,
      QDAC_PTR  = 5'h04,
      QDAC_DATA = 5'h08,
      QDAC_READ = 5'h10
   } qdac_state_t;

   // ==========================================================
   // output stage modes
   typedef enum logic [1:0] {
      QDAC_PM_NORMAL = 2'h0,
      QDAC_PM_1K     = 2'h1,
      QDAC_PM_100K   = 2'h2,
      QDAC_PM_HIZ    = 2'h3
   } qdac_pmode_t;

   // one channel as seen by the conversion stage
   typedef struct packed {
      qdac_pmode_t power_mode;
      logic [11:0] code;
   } qdac_chan_t;

   // line events found on the sampled bus
   typedef struct packed {
      logic start;
      logic stop;
      logic scl_rise;
      logic scl_fall;
      logic sda;
   } qdac_line_ev_t;

endpackage
`default_nettype wire

//--- rtl/qdac_chan_bank.sv
// input and output registers of the four channels
// assumes one-cycle write strobes from the bus sequencer
`timescale 1ns/100ps
`default_nettype none
`include "qdac_defines.svh"
module qdac_chan_bank
   import qdac_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              wr_stb,
   input  wire logic [3:0]        wr_sel,
   input  wire logic [15:0]       wr_word,
   output logic [3:0][15:0]       in_words,
   output qdac_chan_t [3:0]       chan_out
);
   logic [3:0] dirty_ff;
   logic       clearing;
   logic       loading;

   // decode of the control bits of a finished word
   assign clearing = wr_stb & ~wr_word[`QDAC_BIT_CLEAR_N];
   assign loading  = wr_stb & wr_word[`QDAC_BIT_CLEAR_N]
                   & ~wr_word[`QDAC_BIT_LOAD_N];

   // ==========================================================
   // input registers and their fresh flags
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         in_words <= {4{`QDAC_WORD_RST}};
         dirty_ff <= 4'h0;
      end else if (clearing) begin
         in_words <= {4{`QDAC_WORD_RST}};
         dirty_ff <= 4'h0;
      end else if (wr_stb) begin
         for (int i = 0; i < 4; i++) begin
            if (wr_sel[i]) begin
               in_words[i] <= wr_word;
            end
         end
         dirty_ff <= loading ? 4'h0 : (dirty_ff | wr_sel);
      end
   end

   // ==========================================================
   // output registers: codes loaded only from fresh inputs, power modes on each write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 4; i++) begin
            chan_out[i].code       <= `QDAC_CODE_RST;
            chan_out[i].power_mode <= QDAC_PM_NORMAL;
         end
      end else if (wr_stb) begin
         for (int i = 0; i < 4; i++) begin
            if (wr_sel[i]) begin
               chan_out[i].power_mode <= qdac_pmode_t'(
                  wr_word[`QDAC_BIT_PM_HI:`QDAC_BIT_PM_LO]);
            end
            if (clearing) begin
               chan_out[i].code <= `QDAC_CODE_RST;
            end else if (loading && (dirty_ff[i] || wr_sel[i])) begin
               chan_out[i].code <= wr_sel[i] ? wr_word[`QDAC_CODE_MSB:0]
                                             : in_words[i][`QDAC_CODE_MSB:0];
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- rtl/qdac_pin_sync.sv
// two-flop synchroniser for the bus pins
// assumes asynchronous pin levels and one clk domain
`timescale 1ns/100ps
`default_nettype none
module qdac_pin_sync #(
   parameter int WIDTH = 3
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_ff;

   // ==========================================================
   // first stage only feeds the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= '1;
         q       <= '1;
      end else begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end
endmodule
`default_nettype wire

//--- rtl/qdac_two_wire_ctrl.sv
// two-wire slave front end of the quad dac
// holds pin sampling, line events, the byte sequencer
// and the capture of pointer and data words
// assumes scl, sda and the select pin are asynchronous
// and that sda is an open-drain wire resolved outside
`timescale 1ns/100ps
`default_nettype none
`include "qdac_defines.svh"
module qdac_two_wire_ctrl
   import qdac_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        scl_pin,
   input  wire logic        sda_in,
   input  wire logic        address_select_pin,
   output logic             sda_out,
   output logic             sda_oe_n,
   output qdac_chan_t [3:0] chan_out
);

   // ==========================================================
   // helpers

   // own address check on a received address byte
   function automatic logic addr_match(input logic [7:0] b,
                                       input logic       sel);
      addr_match = (b[7:1] == {`QDAC_ADDR_HI, sel});
   endfunction

   // serial bit of the readback word, high byte first
   // idx 0 is the high byte, cnt 0 the msb of a byte
   function automatic logic tx_bit(input logic [15:0] w,
                                   input logic        idx,
                                   input logic [2:0]  cnt);
      tx_bit = w[{~idx, ~cnt}];
   endfunction

   // ==========================================================
   // declarations
   logic [2:0]       pin_s;
   logic             scl_s;
   logic             sda_s;
   logic             sel_s;
   logic             scl_d_ff;
   logic             sda_d_ff;
   qdac_line_ev_t    ev;
   qdac_state_t      state_ff;
   logic [3:0]       bit_cnt_ff;
   logic             byte_idx_ff;
   logic             go_read_ff;
   logic             nack_ff;
   logic [7:0]       shreg_ff;
   logic [7:0]       hi_byte_ff;
   logic [3:0]       ptr_ff;
   logic [15:0]      tx_word_ff;
   logic             wr_stb_ff;
   logic [15:0]      wr_word_ff;
   logic [3:0][15:0] in_words;
   logic [15:0]      rb_word;
   logic             byte_ok;
   logic             byte_end;
   logic             ack_end;
   logic             skip_fall_ff;

   // ==========================================================
   // pin sampling and line events

   // pins pass two flops before any logic
   // the select strap is synced too, it is read at byte end
   qdac_pin_sync #(
      .WIDTH (3)
   ) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({address_select_pin, scl_pin, sda_in}),
      .q     (pin_s)
   );

   assign sel_s = pin_s[2];
   assign scl_s = pin_s[1];
   assign sda_s = pin_s[0];

   // delayed copies for edge finding
   // reset to the idle level so no false edge follows reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_d_ff <= scl_s;
         sda_d_ff <= sda_s;
      end
   end

   // start and stop are sda edges while scl stays high
   always_comb begin
      ev.start    = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
      ev.stop     = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
      ev.scl_rise = scl_s & ~scl_d_ff;
      ev.scl_fall = ~scl_s & scl_d_ff;
      ev.sda      = sda_s;
   end

   // the scl fall that closes a start is not a data bit:
   // counting it would end every byte one bit early
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         skip_fall_ff <= 1'b0;
      end else if (ev.start) begin
         skip_fall_ff <= 1'b1;
      end else if (ev.scl_fall) begin
         skip_fall_ff <= 1'b0;
      end
   end

   // ==========================================================
   // byte boundaries and acknowledge decision

   // a fall masked after a start never closes a byte
   assign byte_end = ev.scl_fall && !skip_fall_ff
                     && (bit_cnt_ff == `QDAC_LAST_BIT);
   assign ack_end  = ev.scl_fall && !skip_fall_ff
                     && (bit_cnt_ff == `QDAC_ACK_BIT);

   // only the address byte can be refused
   always_comb begin
      byte_ok = 1'b1;
      if (state_ff == QDAC_ADDR) begin
         byte_ok = addr_match(shreg_ff, sel_s);
      end
   end

   // readback word for the stored pointer
   // an empty or multi-channel pointer reads the default
   always_comb begin
      unique case (ptr_ff)
         4'h1:    rb_word = in_words[0];
         4'h2:    rb_word = in_words[1];
         4'h4:    rb_word = in_words[2];
         4'h8:    rb_word = in_words[3];
         default: rb_word = `QDAC_RB_DEFAULT;
      endcase
   end

   // ==========================================================
   // protocol sequencer; sda is only changed on scl falls
   // stop and start win over everything, so a cut frame
   // always leaves the sequencer idle or at a fresh address;
   // sda moves about three clocks after the pin fall, well
   // inside the low half of the bus clock
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff    <= QDAC_IDLE;
         bit_cnt_ff  <= 4'h0;
         byte_idx_ff <= 1'b0;
         go_read_ff  <= 1'b0;
         nack_ff     <= 1'b0;
         sda_oe_n    <= 1'b1;
      end else if (ev.stop) begin
         state_ff    <= QDAC_IDLE;
         bit_cnt_ff  <= 4'h0;
         byte_idx_ff <= 1'b0;
         sda_oe_n    <= 1'b1;
      end else if (ev.start) begin
         state_ff    <= QDAC_ADDR;
         bit_cnt_ff  <= 4'h0;
         byte_idx_ff <= 1'b0;
         sda_oe_n    <= 1'b1;
      end else if (ev.scl_rise && state_ff == QDAC_READ
                   && bit_cnt_ff == `QDAC_ACK_BIT) begin
         nack_ff <= ev.sda;
      end else if (ev.scl_fall && !skip_fall_ff && state_ff != QDAC_IDLE) begin
         if (byte_end) begin
            // eighth bit done: open the acknowledge slot
            bit_cnt_ff <= `QDAC_ACK_BIT;
            if (state_ff == QDAC_ADDR) begin
               go_read_ff <= shreg_ff[0];
            end
            if (state_ff == QDAC_READ) begin
               sda_oe_n <= 1'b1;
            end else if (byte_ok) begin
               sda_oe_n <= 1'b0;
            end else begin
               // foreign address: stay off the bus until a start
               state_ff <= QDAC_IDLE;
            end
         end else if (ack_end) begin
            bit_cnt_ff <= 4'h0;
            unique case (state_ff)
               QDAC_ADDR: begin
                  byte_idx_ff <= 1'b0;
                  if (go_read_ff) begin
                     state_ff <= QDAC_READ;
                     sda_oe_n <= tx_bit(rb_word, 1'b0, 3'h0);
                  end else begin
                     state_ff <= QDAC_PTR;
                     sda_oe_n <= 1'b1;
                  end
               end
               QDAC_PTR: begin
                  state_ff    <= QDAC_DATA;
                  byte_idx_ff <= 1'b0;
                  sda_oe_n    <= 1'b1;
               end
               QDAC_DATA: begin
                  byte_idx_ff <= ~byte_idx_ff;
                  sda_oe_n    <= 1'b1;
               end
               // master ack repeats the word, nack ends the read
               QDAC_READ: begin
                  if (nack_ff) begin
                     state_ff <= QDAC_IDLE;
                     sda_oe_n <= 1'b1;
                  end else begin
                     byte_idx_ff <= ~byte_idx_ff;
                     sda_oe_n    <= tx_bit(tx_word_ff, ~byte_idx_ff, 3'h0);
                  end
               end
               QDAC_IDLE: begin
                  sda_oe_n <= 1'b1;
               end
            endcase
         end else begin
            // next data bit of the byte
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
            if (state_ff == QDAC_READ) begin
               sda_oe_n <= tx_bit(tx_word_ff, byte_idx_ff,
                                  bit_cnt_ff[2:0] + 3'h1);
            end
         end
      end
   end

   // the pin is open drain: only ever pulled low
   // so the enable alone moves the line
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sda_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
      end
   end

   // ==========================================================
   // receive shifter, msb first on scl rises
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shreg_ff <= 8'h00;
      end else if (ev.scl_rise && bit_cnt_ff < `QDAC_ACK_BIT
                   && state_ff != QDAC_IDLE
                   && state_ff != QDAC_READ) begin
         shreg_ff <= {shreg_ff[6:0], ev.sda};
      end
   end

   // readback word captured as the read address is acked
   // so a repeated word can never be torn mid-read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_word_ff <= `QDAC_RB_DEFAULT;
      end else if (ack_end && state_ff == QDAC_ADDR && go_read_ff) begin
         tx_word_ff <= rb_word;
      end
   end

   // ==========================================================
   // pointer and data word capture
   // the strobe lasts one clock and only follows a second byte
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr_ff     <= `QDAC_PTR_RST;
         hi_byte_ff <= 8'h00;
         wr_word_ff <= `QDAC_WORD_RST;
         wr_stb_ff  <= 1'b0;
      end else begin
         wr_stb_ff <= 1'b0;
         if (byte_end && state_ff == QDAC_PTR) begin
            ptr_ff <= shreg_ff[3:0];
         end
         if (byte_end && state_ff == QDAC_DATA) begin
            if (!byte_idx_ff) begin
               hi_byte_ff <= shreg_ff;
            end else begin
               wr_word_ff <= {hi_byte_ff, shreg_ff};
               wr_stb_ff  <= 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // channel register bank
   qdac_chan_bank u_bank (
      .clk      (clk),
      .rst_n    (rst_n),
      .wr_stb   (wr_stb_ff),
      .wr_sel   (ptr_ff),
      .wr_word  (wr_word_ff),
      .in_words (in_words),
      .chan_out (chan_out)
   );

endmodule
`default_nettype wire

//--- tb/qdac_bus_master.sv
// two-wire bus master model
// assumes a resolved open-drain data line with pull-up
`timescale 1ns/100ps
`default_nettype none
module qdac_bus_master (
   input  wire logic clk,
   input  wire logic sda_line,
   output var logic  scl,
   output var logic  sda_drv
);
   // =====
   // line idles high, scl stands still between frames
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask

   // start, or repeated start from a low clock
   task automatic start_cond();
      if (!scl) begin
         tick(2);
         sda_drv = 1'b1;
         tick(4);
         scl = 1'b1;
      end
      tick(2);
      sda_drv = 1'b0;
      tick(2);
      scl = 1'b0;
   endtask

   // data low before the rise, high during it
   task automatic stop_cond();
      tick(2);
      sda_drv = 1'b0;
      tick(4);
      scl = 1'b1;
      tick(2);
      sda_drv = 1'b1;
      tick(4);
   endtask

   // one pulse: data set while low, sampled at the rise
   task automatic clock_bit(input logic b, output logic s);
      tick(2);
      sda_drv = b;
      tick(4);
      scl = 1'b1;
      s = sda_line;
      tick(2);
      scl = 1'b0;
   endtask

   task automatic send_byte(input logic [7:0] d, output logic ack_n);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clock_bit(d[i], s);
      end
      clock_bit(1'b1, ack_n);
   endtask

   // more high acks the byte, low ends with no-acknowledge
   task automatic recv_byte(input logic more, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clock_bit(1'b1, s);
         d[i] = s;
      end
      clock_bit(!more, s);
   endtask
endmodule
`default_nettype wire

//--- tb/qdac_props.sv
// port checker of the two-wire dac control
// assumes it is bound onto qdac_two_wire_ctrl
`timescale 1ns/100ps
`default_nettype none
module qdac_props
   import qdac_pkg::*;
(
   input wire logic             clk,
   input wire logic             rst_n,
   input wire logic             scl_pin,
   input wire logic             sda_in,
   input wire logic             address_select_pin,
   input wire logic             sda_out,
   input wire logic             sda_oe_n,
   input wire qdac_chan_t [3:0] chan_out
);
   // =====
   // bus and register checks
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   property p_pull_low_only;
      sda_out == 1'b0;
   endproperty
   a_pull_low_only: assert property (p_pull_low_only)
      else $error("sda driven high");

   property p_reset_state;
      $rose(rst_n) |-> (chan_out == '0) && sda_oe_n;
   endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("outputs not cleared by reset");

   property p_change_low;
      $changed(sda_oe_n) |-> !scl_pin;
   endproperty
   a_change_low: assert property (p_change_low)
      else $error("sda moved while scl high");

   property p_ack_hold;
      $fell(sda_oe_n) |-> !sda_oe_n [*4];
   endproperty
   a_ack_hold: assert property (p_ack_hold)
      else $error("sda pull dropped early");

   property p_word_on_low;
      $changed(chan_out) |-> $past(scl_pin, 3) == 1'b0;
   endproperty
   a_word_on_low: assert property (p_word_on_low)
      else $error("channel update off the byte end");

   property p_idle_release;
      scl_pin [*8] |-> sda_oe_n;
   endproperty
   a_idle_release: assert property (p_idle_release)
      else $error("sda held while bus idle");

   property p_idle_stable;
      scl_pin [*8] |=> $stable(chan_out);
   endproperty
   a_idle_stable: assert property (p_idle_stable)
      else $error("channel moved while bus idle");

   property p_start_free;
      $fell(sda_in) && scl_pin |-> sda_oe_n;
   endproperty
   a_start_free: assert property (p_start_free)
      else $error("device pulled sda at a start");
endmodule
`default_nettype wire

//--- tb/qdac_two_wire_ctrl_tb_top.sv
// self-checking bench of the two-wire dac control
// assumes the design package, defines and bus master
`timescale 1ns/100ps
`default_nettype none
`include "qdac_defines.svh"
module qdac_two_wire_ctrl_tb_top import qdac_pkg::*;;
   logic             clk;
   logic             rst_n;
   logic             sel;
   wire logic        scl;
   wire logic        drv;
   wire logic        sda_out;
   wire logic        sda_oe_n;
   wire logic        sda_line;
   qdac_chan_t [3:0] chan_out;
   int               bad_count;
   int               comparisons;
   logic [15:0]      e_in [4];
   logic [13:0]      e_out [4];
   logic [3:0]       fresh;

   // =====
   // clock, wire and instances
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   assign sda_line = drv & (sda_oe_n | sda_out); // pull-up wins when released

   qdac_bus_master u_master (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_drv(drv));

   qdac_two_wire_ctrl u_dut (
      .clk(clk), .rst_n(rst_n), .scl_pin(scl), .sda_in(sda_line),
      .address_select_pin(sel), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
      .chan_out(chan_out)
   );

   // =====
   // checking and bus helpers
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run();
      if (bad_count == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   function automatic logic [7:0] addr(input logic rw);
      return {`QDAC_ADDR_HI, sel, rw};
   endfunction

   task automatic send_ok(input logic [7:0] b);
      logic ack_n;
      u_master.send_byte(b, ack_n);
      check("acknowledge", {15'h0, ack_n}, 16'h0);
   endtask

   task automatic write_word(input logic [7:0] ptr, input logic [15:0] w, input logic whole);
      u_master.start_cond();
      send_ok(addr(1'b0));
      send_ok(ptr);
      send_ok(w[15:8]);
      if (whole) begin
         send_ok(w[7:0]);
      end
      u_master.stop_cond();
   endtask

   // readback of one word and its repetition
   task automatic read_back(input logic with_ptr, input logic [7:0] ptr, input logic [15:0] exp);
      logic [7:0] b [4];
      if (with_ptr) begin
         u_master.start_cond();
         send_ok(addr(1'b0));
         send_ok(ptr);
      end
      u_master.start_cond();
      send_ok(addr(1'b1));
      for (int i = 0; i < 4; i++) begin
         u_master.recv_byte(i < 3, b[i]);
      end
      u_master.stop_cond();
      check("readback", {b[0], b[1]}, exp);
      check("repeated readback", {b[2], b[3]}, exp);
   endtask

   // expected registers after a completed word
   function automatic void apply(input logic [3:0] chs, input logic [15:0] w);
      for (int c = 0; c < 4; c++) begin
         if (chs[c]) begin
            e_in[c] = w;
            e_out[c][13:12] = w[15:14];
            fresh[c] = 1'b1;
         end
         if (!w[13]) begin
            e_in[c] = 16'h0;
            e_out[c][11:0] = 12'h0;
            fresh[c] = 1'b0;
         end else if (!w[12] && fresh[c]) begin
            e_out[c][11:0] = e_in[c][11:0];
            fresh[c] = 1'b0;
         end
      end
   endfunction

   task automatic check_outs();
      for (int c = 0; c < 4; c++) begin
         check("channel", {2'h0, chan_out[c]}, {2'h0, e_out[c]});
      end
   endtask

   // =====
   // main sequence
   initial begin
      logic [3:0]  chs;
      logic [15:0] w;
      logic        ack_n;
      bad_count = 0;
      comparisons = 0;
      rst_n = 1'b0;
      sel = 1'b0;
      fresh = 4'h0;
      for (int c = 0; c < 4; c++) begin
         e_in[c] = 16'h0;
         e_out[c] = 14'h0;
      end
      void'($urandom(97));
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      check_outs();
      // both straps: foreign address ignored, bare read gives default
      for (int s = 0; s < 2; s++) begin
         sel = s[0];
         repeat (4) @(negedge clk);
         u_master.start_cond();
         u_master.send_byte({`QDAC_ADDR_HI, ~sel, 1'b0}, ack_n);
         check("foreign address", {15'h0, ack_n}, 16'h1);
         u_master.stop_cond();
         read_back(1'b0, 8'h00, 16'h2000);
      end
      // random codes, load bits and channel sets, all four modes in turn
      for (int i = 0; i < 16; i++) begin
         chs = 4'h1 << $urandom_range(3, 0);
         if (i % 4 == 3) begin
            chs = 4'($urandom_range(15, 1));
         end
         w = {i[1:0], 1'b1, 1'($urandom_range(1, 0)), 12'($urandom)};
         write_word({2'($urandom), 2'h0, chs}, w, 1'b1);
         apply(chs, w);
         check_outs();
         read_back(i[0], {4'h0, chs}, $onehot(chs) ? w : 16'h2000);
      end
      // a lone first data byte writes nothing
      write_word(8'h0f, 16'h2fff, 1'b0);
      check_outs();
      // clear bit low zeroes every channel code
      write_word(8'h01, 16'h1abc, 1'b1);
      apply(4'h1, 16'h1abc);
      check_outs();
      complete_run();
   end

   // watchdog against a hung bus
   initial begin
      #1500000;
      bad_count++;
      complete_run();
   end
endmodule

bind qdac_two_wire_ctrl qdac_props u_props (
   .clk(clk), .rst_n(rst_n), .scl_pin(scl_pin), .sda_in(sda_in),
   .address_select_pin(address_select_pin), .sda_out(sda_out),
   .sda_oe_n(sda_oe_n), .chan_out(chan_out)
);
`default_nettype wire
